// file: rtl/cetm_core.sv
// Cycle accounting engine for effective-address and move timing.
// A request names the operand modes and size; the block looks up the clock and
// bus-cycle budget, then plays it out: idle clocks first, then reads, then writes.
// Assumes all inputs are synchronous to clk.
`timescale 1ns/1ps

// Function
// (RULE1) Zero-wait read and write take four clocks
// (RULE2) Wait states stretch cycles, add to total
// (RULE3) Timing is clocks plus reads plus writes
// (RULE4) Leftover clocks are bus-idle internal work
// (RULE5) Total includes fetch, operand fetch and store
// (RULE6) Address calculation never writes the bus
// (RULE7) Register direct modes cost nothing
// (RULE8) Indirect, postincrement: 4/1, long 8/2
// (RULE9) Predecrement 6/10, displacement 8/12 clocks
// (RULE10) Indexed 10/14, absolute short 8/12
// (RULE11) Absolute long 12/16, PC displacement 8/12
// (RULE12) PC indexed 10/14, immediate 4/8
// (RULE13) Index register size does not matter
// (RULE14) Move sums fetch, source reads, destination writes
// (RULE15) Byte/word move register, memory, absolute costs
// (RULE16) Long move register, memory, absolute costs
// (RULE17) Idle is total minus bus clocks; flag negative
module cetm_core (
	input wire logic clk, // Processor clock, 200 MHz
	input wire logic rst_b, // Sync reset, active low
	input wire logic start, // Request pulse, taken when idle
	input wire logic op_move, // 1: move, 0: address calculation
	input wire logic op_long, // Long operand size
	input wire cetm_pkg::cetm_mode_t src_mode, // Source operand mode
	input wire cetm_pkg::cetm_mode_t dst_mode, // Destination mode (move only)
	input wire logic mem_ready, // Memory ready, low inserts waits
	output logic busy, // Request in progress
	output logic done, // One-cycle end pulse
	output logic bus_rd, // Read bus cycle active
	output logic bus_wr, // Write bus cycle active
	output logic [1:0] bus_phase, // Phase of the bus cycle
	output logic [7:0] total_clocks, // Budgeted clocks
	output logic [3:0] read_count, // Budgeted reads
	output logic [3:0] write_count, // Budgeted writes
	output logic [7:0] idle_count, // Budgeted idle clocks
	output logic [15:0] elapsed, // Clocks spent incl. waits
	output logic [15:0] wait_count, // Wait clocks inserted
	output logic table_err, // Idle came out negative
	output logic mode_err // Illegal mode requested
);
	import cetm_pkg::*;

	typedef enum logic [1:0] {
		CETM_S_IDLE = 2'b00,
		CETM_S_LOAD = 2'b01,
		CETM_S_RUN = 2'b10,
		CETM_S_END = 2'b11
	} cetm_fsm_t;

	typedef struct packed {
		cetm_fsm_t fsm;
		logic mv;
		logic lng;
		cetm_mode_t src;
		cetm_mode_t dst;
		logic [7:0] total;
		logic [3:0] rd;
		logic [3:0] wr;
		logic [7:0] idle;
		logic [7:0] idle_left;
		logic [3:0] rd_left;
		logic [3:0] wr_left;
		logic bus_rd;
		logic bus_wr;
		logic busy;
		logic done;
		logic table_err;
		logic mode_err;
		logic [15:0] elapsed;
		logic [15:0] waits;
	} cetm_state_t;

	cetm_state_t st;
	cetm_state_t next_st;

	logic [7:0] src_clk;
	logic [3:0] src_rd;
	logic [3:0] src_wr;
	logic src_bad;
	logic [7:0] dst_clk;
	logic [3:0] dst_rd;
	logic [3:0] dst_wr;
	logic dst_bad;
	logic eng_active;
	logic [1:0] eng_phase;
	logic eng_wait;
	logic eng_last;
	logic go;
	logic [7:0] sum_clk;
	logic [3:0] sum_rd;
	logic [3:0] sum_wr;
	logic [6:0] bus_clks;
	logic [8:0] idle_raw;
	logic work_left;
	logic bus_free;

	// ****************************************
	// Operand cost lookups
	// ****************************************
	cetm_ea_cost #(.DEST(1'b0)) u_src_cost (
		.mode(st.src),
		.lng(st.lng),
		.clk_cost(src_clk),
		.rd_cost(src_rd),
		.wr_cost(src_wr),
		.bad(src_bad)
	);

	cetm_ea_cost #(.DEST(1'b1)) u_dst_cost (
		.mode(st.dst),
		.lng(st.lng),
		.clk_cost(dst_clk),
		.rd_cost(dst_rd),
		.wr_cost(dst_wr),
		.bad(dst_bad)
	);

	// ****************************************
	// Bus cycle sequencer
	// ****************************************
	cetm_bus_engine u_bus (
		.clk(clk),
		.rst_b(rst_b),
		.go(go),
		.mem_ready(mem_ready),
		.active(eng_active),
		.phase(eng_phase),
		.wait_clk(eng_wait),
		.last(eng_last)
	);

	// Budget: move adds fetch and destination, address calculation is source only
	always_comb begin
		sum_clk = src_clk; // RULE7 RULE13
		sum_rd = src_rd;
		sum_wr = src_wr; // RULE6
		if (st.mv) begin
			sum_clk = CETM_FETCH_CLK + src_clk + dst_clk; // RULE14 RULE5
			sum_rd = CETM_FETCH_RD + src_rd + dst_rd; // RULE15 RULE16
			sum_wr = dst_wr;
		end
		bus_clks = {3'h0, sum_rd} + {3'h0, sum_wr};
		bus_clks = {bus_clks[4:0], 2'b00}; // Four clocks per bus cycle
		idle_raw = {1'b0, sum_clk} - {2'b00, bus_clks}; // RULE17 RULE4
	end

	// Issue control: next bus cycle follows the last idle clock or the previous cycle
	always_comb begin
		work_left = (st.rd_left != 4'h0) || (st.wr_left != 4'h0);
		bus_free = !eng_active || eng_last;
		go = (st.fsm == CETM_S_RUN) && work_left &&
			((st.idle_left == 8'h01) || (st.idle_left == 8'h00 && bus_free)); // RULE4
	end

	// ****************************************
	// Control state machine
	// ****************************************
	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		case (st.fsm)
			CETM_S_IDLE: begin
				if (start) begin
					next_st.fsm = CETM_S_LOAD;
					next_st.mv = op_move;
					next_st.lng = op_long;
					next_st.src = src_mode;
					next_st.dst = dst_mode;
					next_st.busy = 1'b1;
					next_st.table_err = 1'b0;
					next_st.mode_err = 1'b0;
					next_st.elapsed = 16'h0000;
					next_st.waits = 16'h0000;
				end
			end
			CETM_S_LOAD: begin
				next_st.total = sum_clk; // RULE3
				next_st.rd = sum_rd;
				next_st.wr = sum_wr;
				next_st.idle = idle_raw[7:0];
				next_st.idle_left = idle_raw[7:0];
				next_st.rd_left = sum_rd;
				next_st.wr_left = sum_wr;
				next_st.mode_err = src_bad || (st.mv && dst_bad);
				next_st.table_err = idle_raw[8]; // RULE17
				if (src_bad || (st.mv && dst_bad) || idle_raw[8]) begin
					next_st.fsm = CETM_S_END;
				end else begin
					next_st.fsm = CETM_S_RUN;
				end
			end
			CETM_S_RUN: begin
				if (st.idle_left != 8'h00) begin
					next_st.idle_left = st.idle_left - 8'h01; // RULE4
					next_st.elapsed = st.elapsed + 16'h0001;
				end else if (eng_active) begin
					next_st.elapsed = st.elapsed + 16'h0001; // RULE2
				end
				if (eng_wait) begin
					next_st.waits = st.waits + 16'h0001; // RULE2
				end
				if (go) begin
					next_st.bus_rd = (st.rd_left != 4'h0);
					next_st.bus_wr = (st.rd_left == 4'h0);
					if (st.rd_left != 4'h0) begin
						next_st.rd_left = st.rd_left - 4'h1;
					end else begin
						next_st.wr_left = st.wr_left - 4'h1;
					end
				end else if (eng_last) begin
					next_st.bus_rd = 1'b0;
					next_st.bus_wr = 1'b0;
				end
				if (!work_left && st.idle_left == 8'h00 && bus_free) begin
					next_st.fsm = CETM_S_END;
				end
			end
			CETM_S_END: begin
				next_st.fsm = CETM_S_IDLE;
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
			end
			default: begin
				next_st.fsm = CETM_S_IDLE;
			end
		endcase
	end

	// Registered state
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign busy = st.busy;
	assign done = st.done;
	assign bus_rd = st.bus_rd;
	assign bus_wr = st.bus_wr;
	assign bus_phase = eng_phase;
	assign total_clocks = st.total;
	assign read_count = st.rd;
	assign write_count = st.wr;
	assign idle_count = st.idle;
	assign elapsed = st.elapsed;
	assign wait_count = st.waits;
	assign table_err = st.table_err;
	assign mode_err = st.mode_err;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	logic [3:0] seen_rd;
	logic [3:0] seen_wr;

	// Completed bus cycles of the current request
	always_ff @(posedge clk) begin
		if (!rst_b || st.fsm == CETM_S_LOAD) begin
			seen_rd <= 4'h0;
			seen_wr <= 4'h0;
		end else if (eng_last) begin
			seen_rd <= seen_rd + {3'h0, st.bus_rd};
			seen_wr <= seen_wr + {3'h0, st.bus_wr};
		end
	end

	sequence s_open_no_wait;
		eng_active && eng_phase == 2'h0 ##1 eng_phase == 2'h1 ##1
			(eng_phase == 2'h2 && mem_ready);
	endsequence

	sequence s_close;
		eng_phase == 2'h3 ##1 (!eng_active || eng_phase == 2'h0);
	endsequence

	a_bus_four_clk: assert property (s_open_no_wait |=> s_close) // RULE1
		else $error("bus cycle without waits did not end after four clocks");
	a_wait_adds: assert property (done && !table_err && !mode_err |-> // RULE2
		elapsed == {8'h00, total_clocks} + wait_count)
		else $error("elapsed clocks differ from budget plus waits");
	a_cycle_counts: assert property (done && !table_err && !mode_err |-> // RULE3
		seen_rd == read_count && seen_wr == write_count)
		else $error("executed bus cycles differ from budget");
	a_idle_quiet: assert property (st.fsm == CETM_S_RUN && st.idle_left > 8'h01 |-> // RULE4
		!eng_active && !bus_rd && !bus_wr ##1 !eng_active)
		else $error("bus active during idle clocks");
	a_idle_split: assert property (done && !table_err && !mode_err |-> // RULE17
		{1'b0, idle_count} == {1'b0, total_clocks} - {read_count + write_count, 2'b00})
		else $error("idle clocks do not match total minus bus clocks");
	a_ea_no_write: assert property (busy && !st.mv |-> !bus_wr) // RULE6
		else $error("address calculation drove a write cycle");
	a_abs_long_move: assert property (start && !busy && op_move && op_long && // RULE16
		src_mode == CETM_ABS_L && dst_mode == CETM_ABS_L |-> ##2
		total_clocks == 8'h24 && read_count == 4'h7 && write_count == 4'h2)
		else $error("long absolute move budget wrong");
	a_reg_move_bw: assert property (start && !busy && op_move && !op_long && // RULE15
		src_mode == CETM_DREG && dst_mode == CETM_IND |-> ##2
		total_clocks == 8'h08 && read_count == 4'h1 && write_count == 4'h1)
		else $error("register to indirect move budget wrong");
	a_predec_long: assert property (start && !busy && !op_move && op_long && // RULE9
		src_mode == CETM_PREDEC |-> ##2
		total_clocks == 8'h0A && read_count == 4'h2 && idle_count == 8'h02)
		else $error("predecrement long budget wrong");
	a_reg_direct: assert property (start && !busy && !op_move && src_mode == CETM_AREG |-> // RULE7
		##4 done && total_clocks == 8'h00 && read_count == 4'h0)
		else $error("register direct mode not free");
	a_err_ends: assert property (st.fsm == CETM_S_LOAD && idle_raw[8] |-> // RULE17
		##1 table_err ##1 done)
		else $error("negative idle not flagged");
	a_err_exit: assert property (st.fsm == CETM_S_LOAD && // RULE3
		(src_bad || (st.mv && dst_bad)) |-> ##1 mode_err ##1 done)
		else $error("illegal mode not flagged");
	a_wait_holds: assert property (eng_wait |=> eng_active && eng_phase == CETM_PH_WAIT) // RULE2
		else $error("wait clock did not hold the bus phase");
	a_reads_first: assert property (bus_wr |-> st.rd_left == 4'h0) // RULE14
		else $error("write cycle ran before all reads");
	a_one_kind: assert property (!(bus_rd && bus_wr)) // RULE3
		else $error("read and write flagged together");
	a_done_pulse: assert property (done |-> !busy ##1 !done) // RULE3
		else $error("end pulse longer than one clock");
	a_ind_word: assert property (start && !busy && !op_move && !op_long && // RULE8
		src_mode == CETM_IND |-> ##2 total_clocks == 8'h04 && read_count == 4'h1)
		else $error("indirect word budget wrong");
	a_index_word: assert property (start && !busy && !op_move && !op_long && // RULE10
		src_mode == CETM_INDEX |-> ##2 total_clocks == 8'h0A && read_count == 4'h2)
		else $error("indexed word budget wrong");
	a_abs_long_ea: assert property (start && !busy && !op_move && op_long && // RULE11
		src_mode == CETM_ABS_L |-> ##2 total_clocks == 8'h10 && read_count == 4'h4)
		else $error("absolute long address budget wrong");
	a_imm_long: assert property (start && !busy && !op_move && op_long && // RULE12
		src_mode == CETM_IMM |-> ##2 total_clocks == 8'h08 && read_count == 4'h2)
		else $error("immediate long budget wrong");

endmodule // cetm_core

// file: rtl/cetm_pkg.sv
// Package of the instruction cycle-accounting block: modes, cost tables, bus timing.
// Assumes a 16-bit bus core whose bus cycles run on the same clock as this block.
package cetm_pkg;

	// ****************************************
	// Operand addressing modes
	// ****************************************
	typedef enum logic [3:0] {
		CETM_DREG = 4'h0, // data_reg_operand direct
		CETM_AREG = 4'h1, // addr_reg_operand direct
		CETM_IND = 4'h2,
		CETM_POSTINC = 4'h3,
		CETM_PREDEC = 4'h4,
		CETM_DISP16 = 4'h5,
		CETM_INDEX = 4'h6, // with index_reg_operand
		CETM_ABS_W = 4'h7,
		CETM_ABS_L = 4'h8,
		CETM_PC_DISP = 4'h9,
		CETM_PC_INDEX = 4'hA,
		CETM_IMM = 4'hB
	} cetm_mode_t;

	// ****************************************
	// Timing counts
	// ****************************************
	localparam int CETM_NMODES = 12;
	localparam logic [7:0] CETM_BUS_CLKS = 8'h04; // Clocks per zero-wait bus cycle
	localparam logic [1:0] CETM_PH_WAIT = 2'h2; // Phase where wait states stretch
	localparam logic [1:0] CETM_PH_LAST = 2'h3;
	localparam logic [7:0] CETM_FETCH_CLK = 8'h04; // Opcode fetch of a move
	localparam logic [3:0] CETM_FETCH_RD = 4'h1;

	// ****************************************
	// Source operand costs, indexed by mode
	// ****************************************
	localparam logic [7:0] CETM_SRC_CLK_BW [CETM_NMODES] =
		'{8'h00, 8'h00, 8'h04, 8'h04, 8'h06, 8'h08, 8'h0A, 8'h08, 8'h0C, 8'h08, 8'h0A, 8'h04};
	localparam logic [3:0] CETM_SRC_RD_BW [CETM_NMODES] =
		'{4'h0, 4'h0, 4'h1, 4'h1, 4'h1, 4'h2, 4'h2, 4'h2, 4'h3, 4'h2, 4'h2, 4'h1};
	localparam logic [7:0] CETM_SRC_CLK_L [CETM_NMODES] =
		'{8'h00, 8'h00, 8'h08, 8'h08, 8'h0A, 8'h0C, 8'h0E, 8'h0C, 8'h10, 8'h0C, 8'h0E, 8'h08};
	localparam logic [3:0] CETM_SRC_RD_L [CETM_NMODES] =
		'{4'h0, 4'h0, 4'h2, 4'h2, 4'h2, 4'h3, 4'h3, 4'h3, 4'h4, 4'h3, 4'h3, 4'h2};

	// ****************************************
	// Destination operand costs, indexed by mode
	// ****************************************
	localparam logic [7:0] CETM_DST_CLK_BW [CETM_NMODES] =
		'{8'h00, 8'h00, 8'h04, 8'h04, 8'h04, 8'h08, 8'h0A, 8'h08, 8'h0C, 8'h00, 8'h00, 8'h00};
	localparam logic [3:0] CETM_DST_RD_BW [CETM_NMODES] =
		'{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h1, 4'h1, 4'h2, 4'h0, 4'h0, 4'h0};
	localparam logic [3:0] CETM_DST_WR_BW [CETM_NMODES] =
		'{4'h0, 4'h0, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h0, 4'h0, 4'h0};
	localparam logic [7:0] CETM_DST_CLK_L [CETM_NMODES] =
		'{8'h00, 8'h00, 8'h08, 8'h08, 8'h08, 8'h0C, 8'h0E, 8'h0C, 8'h10, 8'h00, 8'h00, 8'h00};
	localparam logic [3:0] CETM_DST_RD_L [CETM_NMODES] =
		'{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h1, 4'h1, 4'h2, 4'h0, 4'h0, 4'h0};
	localparam logic [3:0] CETM_DST_WR_L [CETM_NMODES] =
		'{4'h0, 4'h0, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h0, 4'h0, 4'h0};

endpackage

// file: rtl/cetm_ea_cost.sv
// Operand cost lookup: clocks, reads and writes for one operand mode and size.
// Purely combinational; the caller registers what it keeps.
`timescale 1ns/1ps
module cetm_ea_cost #(
	parameter bit DEST = 1'b0 // 1: destination (store) costs
) (
	input wire cetm_pkg::cetm_mode_t mode, // Operand mode
	input wire logic lng, // Long operand
	output logic [7:0] clk_cost, // Clock periods
	output logic [3:0] rd_cost, // Read bus cycles
	output logic [3:0] wr_cost, // Write bus cycles
	output logic bad // Mode not legal here
);
	import cetm_pkg::*;

	// ****************************************
	// Table lookup
	// ****************************************
	always_comb begin
		clk_cost = 8'h00;
		rd_cost = 4'h0;
		wr_cost = 4'h0;
		bad = (mode > CETM_IMM) || (DEST && mode > CETM_ABS_L);
		if (!bad) begin
			if (DEST) begin
				clk_cost = lng ? CETM_DST_CLK_L[mode] : CETM_DST_CLK_BW[mode]; // RULE15 RULE16
				rd_cost = lng ? CETM_DST_RD_L[mode] : CETM_DST_RD_BW[mode];
				wr_cost = lng ? CETM_DST_WR_L[mode] : CETM_DST_WR_BW[mode];
			end else begin
				clk_cost = lng ? CETM_SRC_CLK_L[mode] : CETM_SRC_CLK_BW[mode]; // RULE8 RULE9 RULE10
				rd_cost = lng ? CETM_SRC_RD_L[mode] : CETM_SRC_RD_BW[mode]; // RULE11 RULE12 RULE7
				wr_cost = 4'h0; // RULE6
			end
		end
	end

endmodule // cetm_ea_cost

// file: rtl/cetm_bus_engine.sv
// Bus cycle sequencer: four phases per cycle, stretched in phase 2 by wait states.
// Assumes mem_ready is synchronous to clk.
`timescale 1ns/1ps
module cetm_bus_engine (
	input wire logic clk, // Processor clock
	input wire logic rst_b, // Sync reset, active low
	input wire logic go, // Start a bus cycle next clock
	input wire logic mem_ready, // Memory can finish this cycle
	output logic active, // Bus cycle in progress
	output logic [1:0] phase, // Current phase
	output logic wait_clk, // This clock is a wait state
	output logic last // Last clock of the cycle
);
	import cetm_pkg::*;

	typedef struct packed {
		logic active;
		logic [1:0] phase;
	} cetm_eng_t;

	cetm_eng_t st;
	cetm_eng_t next_st;

	// ****************************************
	// Phase stepping
	// ****************************************
	always_comb begin
		next_st = st;
		wait_clk = st.active && st.phase == CETM_PH_WAIT && !mem_ready; // RULE2
		last = st.active && st.phase == CETM_PH_LAST;
		if (go) begin
			next_st.active = 1'b1;
			next_st.phase = 2'h0;
		end else if (last) begin
			next_st.active = 1'b0;
			next_st.phase = 2'h0;
		end else if (st.active && !wait_clk) begin
			next_st.phase = st.phase + 2'h1; // RULE1
		end
	end

	// Registered state
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign active = st.active;
	assign phase = st.phase;

endmodule // cetm_bus_engine

// file: verif/cetm_mem_model.sv
// Memory and peripheral model on the far side of the cycle-accounting block.
// Assumes bus_rd, bus_wr and bus_phase are registered on clk; waits comes from the bench.
`timescale 1ns/1ps
module cetm_mem_model (
	input wire logic clk, // Processor clock
	input wire logic rst_b, // Sync reset, active low
	input wire logic bus_rd, // Read cycle active
	input wire logic bus_wr, // Write cycle active
	input wire logic [1:0] bus_phase, // Phase of the cycle
	input wire logic [3:0] waits, // Wait clocks per cycle
	output logic mem_ready // High when the cycle may finish
);
	logic [3:0] wcnt;
	logic junk;
	logic stretch;

	// Stretch phase of a running bus cycle
	assign stretch = (bus_rd || bus_wr) && bus_phase == 2'h2;

	// Count wait clocks, and keep a changing pattern for when ready is meaningless
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wcnt <= 4'h0;
			junk <= 1'b0;
		end else begin
			junk <= ~junk;
			if (stretch && wcnt < waits) begin
				wcnt <= wcnt + 4'h1;
			end else begin
				wcnt <= 4'h0;
			end
		end
	end

	// Slow memory holds ready low for the wait count
	assign mem_ready = stretch ? (wcnt >= waits) : junk;
endmodule // cetm_mem_model

// file: verif/cetm_core_tb.sv
// Self-checking bench of the cycle-accounting block.
// Assumes cetm_pkg and cetm_core; the memory model answers bus cycles.
`timescale 1ns/1ps
module cetm_core_tb;
	import cetm_pkg::*;
	typedef struct {logic mv; logic lg; logic [3:0] s; logic [3:0] d;
		logic [7:0] c; logic [3:0] r; logic [3:0] w;} cetm_row_t;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic start = 1'b0;
	logic op_move = 1'b0;
	logic op_long = 1'b0;
	cetm_mode_t src_mode = CETM_DREG;
	cetm_mode_t dst_mode = CETM_DREG;
	logic mem_ready;
	logic [3:0] waits = 4'h0;
	logic busy, done, bus_rd, bus_wr, table_err, mode_err;
	logic [1:0] bus_phase;
	logic [7:0] total_clocks, idle_count;
	logic [3:0] read_count, write_count;
	logic [15:0] elapsed, wait_count;
	int failures = 0;
	int n_tests = 0;
	int n, rcl, wcl, rcy, wcy, raw, k, t1, t2;
	cetm_row_t rows [$];
	cetm_row_t x;
	logic [7:0] ea_c [2][12] = '{
		'{8'h00, 8'h00, 8'h04, 8'h04, 8'h06, 8'h08, 8'h0A, 8'h08, 8'h0C, 8'h08, 8'h0A, 8'h04},
		'{8'h00, 8'h00, 8'h08, 8'h08, 8'h0A, 8'h0C, 8'h0E, 8'h0C, 8'h10, 8'h0C, 8'h0E, 8'h08}};
	logic [3:0] ea_r [2][12] = '{
		'{4'h0, 4'h0, 4'h1, 4'h1, 4'h1, 4'h2, 4'h2, 4'h2, 4'h3, 4'h2, 4'h2, 4'h1},
		'{4'h0, 4'h0, 4'h2, 4'h2, 4'h2, 4'h3, 4'h3, 4'h3, 4'h4, 4'h3, 4'h3, 4'h2}};
	cetm_row_t mv_rows [10] = '{
		'{1'b1, 1'b0, 4'h0, 4'h0, 8'h04, 4'h1, 4'h0}, '{1'b1, 1'b0, 4'h0, 4'h2, 8'h08, 4'h1, 4'h1},
		'{1'b1, 1'b0, 4'h8, 4'h8, 8'h1C, 4'h6, 4'h1}, '{1'b1, 1'b1, 4'h0, 4'h1, 8'h04, 4'h1, 4'h0},
		'{1'b1, 1'b1, 4'h1, 4'h3, 8'h0C, 4'h1, 4'h2}, '{1'b1, 1'b1, 4'h8, 4'h8, 8'h24, 4'h7, 4'h2},
		'{1'b1, 1'b0, 4'h5, 4'h6, 8'h16, 4'h4, 4'h1}, '{1'b1, 1'b1, 4'h4, 4'h7, 8'h1A, 4'h4, 4'h2},
		'{1'b1, 1'b0, 4'hB, 4'h4, 8'h0C, 4'h2, 4'h1}, '{1'b1, 1'b1, 4'hA, 4'h5, 8'h1E, 4'h5, 4'h2}};
	cetm_row_t errs [2] = '{'{1'b0, 1'b0, 4'hC, 4'h0, 8'h00, 4'h0, 4'h0},
		'{1'b1, 1'b0, 4'h0, 4'h9, 8'h00, 4'h0, 4'h0}};

	// Clock, 5 ns period
	always #2.5 clk = ~clk;

	cetm_core dut (.clk(clk), .rst_b(rst_b), .start(start), .op_move(op_move),
		.op_long(op_long), .src_mode(src_mode), .dst_mode(dst_mode), .mem_ready(mem_ready),
		.busy(busy), .done(done), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_phase(bus_phase),
		.total_clocks(total_clocks), .read_count(read_count), .write_count(write_count),
		.idle_count(idle_count), .elapsed(elapsed), .wait_count(wait_count),
		.table_err(table_err), .mode_err(mode_err));

	cetm_mem_model mem (.clk(clk), .rst_b(rst_b), .bus_rd(bus_rd), .bus_wr(bus_wr),
		.bus_phase(bus_phase), .waits(waits), .mem_ready(mem_ready));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask

	// One request: cycles to done, bus clocks, bus cycles, reads after a write
	task automatic req(input cetm_row_t q);
		logic wr_seen;
		wr_seen = 1'b0;
		n = 0;
		rcl = 0;
		wcl = 0;
		rcy = 0;
		wcy = 0;
		raw = 0;
		@(posedge clk);
		start <= 1'b1;
		op_move <= q.mv;
		op_long <= q.lg;
		src_mode <= cetm_mode_t'(q.s);
		dst_mode <= cetm_mode_t'(q.d);
		@(posedge clk);
		start <= 1'b0;
		do begin
			@(negedge clk);
			n++;
			rcl += (bus_rd === 1'b1);
			wcl += (bus_wr === 1'b1);
			rcy += (bus_rd === 1'b1 && bus_phase === 2'h3);
			wcy += (bus_wr === 1'b1 && bus_phase === 2'h3);
			raw += (bus_rd === 1'b1 && wr_seen);
			wr_seen = wr_seen || (bus_wr === 1'b1);
		end while (done !== 1'b1 && n < 400);
		if (n >= 400) begin
			failures++;
			$display("MISMATCH t=%0t no done", $time);
			print_verdict();
		end
	endtask

	// Request plus every budget and play-out comparison
	task automatic run_row(input cetm_row_t q, input int wt);
		int bus;
		int gap;
		bus = q.r + q.w;
		// No idle clocks: one issue clock passes before the first bus cycle
		gap = (int'(q.c) == 4 * bus) ? 1 : 0;
		req(q);
		chk(16'(total_clocks), 16'(q.c), "total");
		chk(16'(read_count), 16'(q.r), "reads");
		chk(16'(write_count), 16'(q.w), "writes");
		chk(16'(idle_count), 16'(int'(q.c) - 4 * bus), "idle");
		chk(elapsed, 16'(int'(q.c) + wt * bus), "elapsed");
		chk(wait_count, 16'(wt * bus), "waits");
		chk(16'(n), 16'(int'(q.c) + wt * bus + 3 + gap), "done time");
		chk(16'(rcl), 16'((4 + wt) * q.r), "read clocks");
		chk(16'(wcl), 16'((4 + wt) * q.w), "write clocks");
		chk(16'(rcy + wcy), 16'(bus), "bus cycles");
		chk(16'(raw), 16'h0000, "read after write");
		chk(16'({table_err, mode_err}), 16'h0000, "flags");
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (12) @(posedge clk);
		chk(16'({busy, done, bus_rd, bus_wr, mode_err}), 16'h0000, "reset outputs");
		rst_b <= 1'b1;
		// Address calculation for every mode and size, then the move rows
		for (int l = 0; l < 2; l++) begin
			for (int m = 0; m < 12; m++) begin
				rows.push_back('{1'b0, l[0], 4'(m), 4'h0, ea_c[l][m], ea_r[l][m], 4'h0});
			end
		end
		foreach (mv_rows[i]) rows.push_back(mv_rows[i]);
		foreach (rows[i]) begin
			run_row(rows[i], 0);
		end
		// Slow memory: two wait clocks per bus cycle
		waits <= 4'h2;
		run_row(rows[16], 2);
		run_row(mv_rows[7], 2);
		waits <= 4'h0;
		// Illegal modes end quickly with no bus traffic
		foreach (errs[i]) begin
			req(errs[i]);
			chk(16'(mode_err), 16'h0001, "mode error");
			chk(16'(n), 16'h0003, "error done time");
			chk(16'(rcl + wcl), 16'h0000, "error bus");
		end
		// Held request: ignored while busy, taken again the cycle done is high
		@(posedge clk);
		start <= 1'b1;
		op_move <= 1'b0;
		op_long <= 1'b1;
		src_mode <= CETM_ABS_L;
		n = 0;
		k = 0;
		t1 = 0;
		t2 = 0;
		while (k < 2 && n < 400) begin
			@(negedge clk);
			n++;
			if (done === 1'b1) begin
				k++;
				t2 = n;
				if (k == 1) t1 = n;
			end
		end
		if (k < 2) begin
			failures++;
			$display("MISMATCH t=%0t no second done", $time);
		end
		chk(16'(t2 - t1), 16'h0014, "back to back");
		chk(16'(total_clocks), 16'h0010, "held total");
		// Reset in mid request clears everything
		@(posedge clk);
		start <= 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk(16'({busy, done, bus_rd, bus_wr}), 16'h0000, "mid reset");
		chk(16'(total_clocks) | elapsed, 16'h0000, "mid reset counts");
		@(posedge clk);
		rst_b <= 1'b1;
		run_row(mv_rows[2], 0);
		print_verdict();
	end
endmodule // cetm_core_tb
